//--- dac_port_pkg.sv
// Purpose: shared constants and carriers for the serial dac write port
// Assumes: word is 16 bits, msb first, two leading and two trailing don't-care bits
// Notes: mode codes follow the two mode bits of the word
package dac_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 10;
  localparam int CNT_BITS = 5;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CODE_LSB_POS = 2;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h10;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
  localparam logic [CODE_BITS-1:0] CODE_FULL = 10'h3FF;
  // host side limits, kept for reference; the port and its checkers do not use them
  localparam int SCLK_MAX_MHZ = 30;
  localparam int SYNC_HIGH_MIN_NS = 33;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_HIGH_MIN_CYC =
    (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PD_1K,
    MODE_PD_100K,
    MODE_PD_TRISTATE
  } mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } frame_e;

  typedef struct packed {
    logic [CODE_BITS-1:0] code;
    mode_e mode;
  } dac_out_s;

  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } pins_s;
endpackage

//--- serial_dac_write_port.sv
// Purpose: write-only three-wire serial port of a 10-bit dac, sampled on the system clock
// Assumes: clk much faster than the serial clock; pins are asynchronous to clk
// Notes: serial clock edges are found by oversampling, not used as a clock
`timescale 1ns/1ps
module serial_dac_write_port #(
  // word shape; the field positions are fixed, so only these values elaborate
  parameter int WORD_BITS = dac_port_pkg::WORD_BITS,
  parameter int CODE_BITS = dac_port_pkg::CODE_BITS,
  parameter int CNT_BITS = dac_port_pkg::CNT_BITS
) (
  // system
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  // dac control
  output logic [dac_port_pkg::CODE_BITS-1:0] dac_code,
  output dac_port_pkg::mode_e dac_mode,
  output logic powered_down,
  output logic update_pulse
);

  // shapes the logic cannot serve are refused at elaboration
  if (WORD_BITS != dac_port_pkg::WORD_BITS) begin : g_word_chk
    $error("only a sixteen bit word is supported");
  end

  if (CODE_BITS != dac_port_pkg::CODE_BITS) begin : g_code_chk
    $error("only a ten bit code is supported");
  end

  if (CNT_BITS != dac_port_pkg::CNT_BITS) begin : g_cnt_chk
    $error("bit counter width must follow the package");
  end

  if ((1 << CNT_BITS) <= WORD_BITS) begin : g_cnt_room
    $error("bit counter cannot reach the last bit of a word");
  end

  if (dac_port_pkg::CODE_LSB_POS + CODE_BITS != dac_port_pkg::MODE_LO_POS) begin : g_field_chk
    $error("code field must sit right below the mode bits");
  end

  if (dac_port_pkg::LAST_BIT != WORD_BITS) begin : g_last_chk
    $error("last bit count must equal the word width");
  end

  // pin levels loaded by reset; sync_n high so no frame opens falsely
  localparam dac_port_pkg::pins_s PINS_IDLE = '{sync_n: 1'b1, sclk: 1'b0, din: 1'b0};

  typedef struct packed {
    // pin pipeline: two synchroniser stages, then one for edge finding
    dac_port_pkg::pins_s meta;
    dac_port_pkg::pins_s sync;
    dac_port_pkg::pins_s prev;
    // frame tracking
    dac_port_pkg::frame_e state;
    logic [dac_port_pkg::WORD_BITS-1:0] shift;
    logic [dac_port_pkg::CNT_BITS-1:0] count;
    // applied word
    dac_port_pkg::dac_out_s out;
    logic pd;
    logic upd;
  } state_s;

  state_s q;
  state_s d;

  // level change between the two newest synchronised samples
  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return !prev && cur;
  endfunction

  // msb arrives first, so each new bit enters at the bottom
  function automatic logic [dac_port_pkg::WORD_BITS-1:0] shift_in(
    input logic [dac_port_pkg::WORD_BITS-1:0] w,
    input logic b);
    return {w[dac_port_pkg::WORD_BITS-2:0], b};
  endfunction

  // true when the bit now arriving is the sixteenth of the frame
  function automatic logic is_last(input logic [dac_port_pkg::CNT_BITS-1:0] c);
    logic [dac_port_pkg::CNT_BITS-1:0] n;
    n = c + 1'b1;
    return n == dac_port_pkg::LAST_BIT;
  endfunction

  // straight binary code passes untouched to the string
  function automatic dac_port_pkg::dac_out_s decode_word(
    input logic [dac_port_pkg::WORD_BITS-1:0] w);
    dac_port_pkg::dac_out_s r;
    r.mode = dac_port_pkg::mode_e'({w[dac_port_pkg::MODE_HI_POS],
                                    w[dac_port_pkg::MODE_LO_POS]});
    r.code = w[dac_port_pkg::CODE_LSB_POS +: dac_port_pkg::CODE_BITS];
    return r;
  endfunction

  // any mode but normal parks the output stage; the code is still loaded from the word
  function automatic logic powers_down(input dac_port_pkg::mode_e m);
    return m != dac_port_pkg::MODE_NORMAL;
  endfunction

  logic sclk_fall;
  logic sync_rise;
  logic sync_fall;
  logic [dac_port_pkg::WORD_BITS-1:0] next_word;
  dac_port_pkg::dac_out_s next_out;

  // outputs move three clk edges after the pin edge of the sixteenth fall;
  // the serial clock must stay high and low two clk periods each, which
  // the limit on its rate keeps only when clk is fast enough
  always_comb begin
    d = q;
    // two-stage synchroniser; the first stage feeds no logic
    d.meta = '{sync_n: sync_n, sclk: sclk, din: din};
    d.sync = q.meta;
    d.prev = q.sync;
    d.upd = 1'b0;
    sclk_fall = fell(q.prev.sclk, q.sync.sclk);
    sync_rise = rose(q.prev.sync_n, q.sync.sync_n);
    sync_fall = fell(q.prev.sync_n, q.sync.sync_n);
    // din travels beside sclk through the same flops, so it is valid at the fall
    next_word = shift_in(q.shift, q.sync.din);
    next_out = decode_word(next_word);
    case (q.state)
      dac_port_pkg::ST_IDLE: begin
        // a falling sync arms the frame; idling low without a new fall does nothing
        if (sync_fall) begin
          d.state = dac_port_pkg::ST_SHIFT;
          d.count = '0;
          d.shift = '0;
        end else begin
          d.state = dac_port_pkg::ST_IDLE;
        end
      end
      dac_port_pkg::ST_SHIFT: begin
        // abort wins over a fall seen in the same sample
        if (sync_rise) begin
          d.state = dac_port_pkg::ST_IDLE;
          d.shift = '0;
          d.count = '0;
        end else if (sclk_fall) begin
          d.shift = next_word;
          d.count = q.count + 1'b1;
          if (is_last(q.count)) begin
            d.out = next_out;
            d.pd = powers_down(next_out.mode);
            d.upd = 1'b1;
            d.state = dac_port_pkg::ST_DONE;
          end
        end else begin
          // waiting for the next fall
          d.shift = q.shift;
        end
      end
      dac_port_pkg::ST_DONE: begin
        // further edges ignored until sync returns high
        if (sync_rise) begin
          d.state = dac_port_pkg::ST_IDLE;
        end else begin
          // sync may idle low here to save power
          d.state = dac_port_pkg::ST_DONE;
        end
      end
      default: begin
        d.state = dac_port_pkg::ST_IDLE;
      end
    endcase
  end

  // pins settle through the chain within three edges of release
  always_ff @(posedge clk) begin
    if (srst) begin
      q.meta <= PINS_IDLE;
      q.sync <= PINS_IDLE;
      q.prev <= PINS_IDLE;
      q.state <= dac_port_pkg::ST_IDLE;
      q.shift <= '0;
      q.count <= '0;
      q.out.code <= dac_port_pkg::CODE_RESET;
      q.out.mode <= dac_port_pkg::MODE_NORMAL;
      q.pd <= 1'b0;
      q.upd <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // a power-down write loads the code field too, like any other write
  // every output is a flop of the state
  assign dac_code = q.out.code;
  assign dac_mode = q.out.mode;
  assign powered_down = q.pd;
  assign update_pulse = q.upd;

endmodule // serial_dac_write_port

//--- serial_dac_write_port_assertions.sv
// Purpose: port checks for serial_dac_write_port
// Assumes: clk is the only clock, srst its reset
// Notes: attached by bind after the module
`timescale 1ns/1ps
module serial_dac_write_port_checker (
  // system
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  // dac control
  input wire logic [dac_port_pkg::CODE_BITS-1:0] dac_code,
  input wire dac_port_pkg::mode_e dac_mode,
  input wire logic powered_down,
  input wire logic update_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence sclk_quiet_s; $stable(sclk) [*8]; endsequence
  sequence sync_idle_s; sync_n [*8]; endsequence
  rst_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> dac_code == 10'h000 && dac_mode == 2'h0) else $error("reset left outputs set");
  pd_flag_a: assert property (powered_down == (dac_mode != dac_port_pkg::MODE_NORMAL))
    else $error("power down flag wrong");
  code_hold_a: assert property (!update_pulse |-> $stable(dac_code))
    else $error("code moved without update");
  mode_hold_a: assert property (!update_pulse |-> $stable(dac_mode))
    else $error("mode moved without update");
  pulse_one_a: assert property (update_pulse |=> !update_pulse) else $error("long pulse");
  abort_idle_a: assert property (sync_idle_s |-> !update_pulse)
    else $error("update with sync high");
  sclk_need_a: assert property (sclk_quiet_s |-> !update_pulse)
    else $error("update without clock fall");
  frame_open_a: assert property (update_pulse |-> !$past(sync_n, 4))
    else $error("update outside frame");
endmodule // serial_dac_write_port_checker
bind serial_dac_write_port serial_dac_write_port_checker i_chk (.clk, .srst, .sync_n, .sclk,
  .din, .dac_code, .dac_mode, .powered_down, .update_pulse);

//--- dac_host_model.sv
// Purpose: host side serial writer
// Assumes: inputs change on clk falls
// Notes: sclk rests high between frames; din flips when released
`timescale 1ns/1ps
module dac_host_model (
  // system
  input wire logic clk,
  // serial pins
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // n below 16 aborts, above 16 gives extra falls
  task automatic send(input logic [15:0] w, input int n);
    @(negedge clk) sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din = w[i & 15];
      repeat (6) @(negedge clk);
      sclk = 1'b0;
      repeat (6) @(negedge clk);
      sclk = 1'b1;
    end
    repeat (2) @(negedge clk);
    sync_n = 1'b1;
    din = ~din;
    repeat (5) @(negedge clk);
  endtask
endmodule // dac_host_model

//--- tb_serial_dac_write_port.sv
// Purpose: self-checking bench for serial_dac_write_port
// Assumes: host model drives the pins
// Notes: expectations built from the word layout
`timescale 1ns/1ps
module tb_serial_dac_write_port;
  logic clk;
  logic srst = 1'b1;
  logic sync_n, sclk, din, powered_down, update_pulse;
  logic [9:0] dac_code;
  dac_port_pkg::mode_e dac_mode;
  int num_errors = 0;
  int checked = 0;
  int pulses = 0;
  serial_dac_write_port i_dut (.clk, .srst, .sync_n, .sclk, .din, .dac_code, .dac_mode,
    .powered_down, .update_pulse);
  dac_host_model i_host (.clk, .sync_n, .sclk, .din);
  // counted on the clk fall, half a period after the launching edge, where the pulse has settled
  always @(negedge clk) begin
    if (update_pulse === 1'b1) pulses++;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic expect_out(input logic [1:0] m, input logic [9:0] c);
    check("code", dac_code, c);
    check("mode", {8'h00, dac_mode}, {8'h00, m});
    check("pd", {9'h000, powered_down}, {9'h000, m != 2'h0});
  endtask
  task automatic t_reset();
    expect_out(2'h0, 10'h000);
  endtask
  task automatic t_modes();
    int seen;
    for (int m = 0; m < 4; m++) begin
      seen = pulses;
      i_host.send({2'h2, m[1:0], m[0] ? 10'h000 : 10'h3FF, 2'h1}, 16);
      expect_out(m[1:0], m[0] ? 10'h000 : 10'h3FF);
      check("pulses", 10'(pulses - seen), 10'h001);
    end
  endtask
  task automatic t_abort();
    int seen;
    seen = pulses;
    i_host.send({2'h0, 2'h1, 10'h155, 2'h0}, 15);
    expect_out(2'h3, 10'h000);
    check("pulses", 10'(pulses - seen), 10'h000);
  endtask
  task automatic t_extra();
    int seen;
    seen = pulses;
    i_host.send({2'h3, 2'h0, 10'h2AA, 2'h3}, 18);
    expect_out(2'h0, 10'h2AA);
    check("pulses", 10'(pulses - seen), 10'h001);
  endtask
  task automatic t_midreset();
    @(negedge clk) srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    expect_out(2'h0, 10'h000);
    i_host.send({2'h1, 2'h2, 10'h1FF, 2'h2}, 16);
    expect_out(2'h2, 10'h1FF);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_modes();
    t_abort();
    t_extra();
    t_midreset();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule // tb_serial_dac_write_port
